/* File: inc/mtcu_pkg.sv */
// constants, register map and carrier types of the master timing unit
package mtcu_pkg;
  localparam int CNT_W    = 16;
  localparam int REP_W    = 8;
  localparam int FLG_W    = 7;
  localparam int PSC_W    = 9;
  // register byte offsets
  localparam logic [7:0] OFS_CTL0  = 8'h00;
  localparam logic [7:0] OFS_CTL1  = 8'h04;
  localparam logic [7:0] OFS_INTF  = 8'h08;
  localparam logic [7:0] OFS_INTFC = 8'h0c;
  localparam logic [7:0] OFS_IEN   = 8'h10;
  localparam logic [7:0] OFS_CAR   = 8'h14;
  localparam logic [7:0] OFS_CREP  = 8'h18;
  localparam logic [7:0] OFS_CNT   = 8'h1c;
  localparam logic [3:0] OFS_CMP_HI = 4'h2;
  // fields
  localparam logic [31:0] CTL0_WMASK = 32'h0000_ff3f;
  localparam int SRST_BIT = 0;
  localparam int SUP_BIT  = 1;
  localparam int IE_LSB   = 0;
  localparam int DEN_LSB  = 16;
  localparam logic [1:0] UPDATE_SOURCE_SELECT_DMA  = 2'b01;
  localparam logic [1:0] UPDATE_SOURCE_SELECT_ROLL = 2'b10;
  localparam logic [1:0] DAC_OFF    = 2'b00;
  localparam logic [2:0] DIV_LATE   = 3'b101;
  // reset values
  localparam logic [CNT_W-1:0] CAR_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [REP_W-1:0] REP_RST = 8'h00;

  typedef enum {
    R_CTL0, R_CTL1, R_INTF, R_INTFC, R_IEN,
    R_CAR, R_CREP, R_CNT, R_CMP, R_NONE
  } mtcu_reg_t;

  typedef struct packed {
    logic [15:0] rsvdHi;
    logic        divExt;
    logic [2:0]  clkDiv;
    logic [1:0]  dacSel;
    logic [1:0]  updSrc;
    logic [1:0]  rsvdLo;
    logic        updOnRep;
    logic        syncStartEn;
    logic        syncRstEn;
    logic        preloadEn;
    logic        halfMode;
    logic        cntEnable;
  } mtcu_ctl_t;

  typedef struct packed {
    logic       rep;
    logic       sync;
    logic       upd;
    logic [3:0] cmp;
  } mtcu_flags_t;
endpackage

/* File: hdl/mtcu_timer.sv */
// master timing unit: counter, compares, half mode, shadow update, dac trigger
//
// Overview of operation
// - counter reset to zero by software or sync only while counter enabled
// - soft counter reset bit resets counter then clears itself
// - sync input resets counter only with sync-in reset enable set
// - with division ratio above 64, reset waits for next counter tick
// - four compare registers; event when counter equals active compare value
// - compare event sets compare flag; irq or dma request if enabled
// - writing one to compare flag clear bit clears flag; zero ignored
// - half mode uses period/2 as compare 0; register itself unchanged
// - half value follows update with preload, else period write at once
// - sync input starts counter when sync-in start enable set
// - sync input sets sync flag with irq/dma; write one clears it
// - preload off after reset; writes then reach active registers at once
// - with preload, shadows move to active only on update events
// - enables, period, repetition and four compares are preloadable
// - soft update request updates and cancels pending hardware updates
// - repetition event updates when enabled, except with source select 10
// - source select 01 updates on dma burst completion
// - source select 10 updates on first roll-over after dma completion
// - update sets update flag with irq/dma; write one clears it
// - update pulses one of three dac triggers unless select is 00
// - continuous counting from enable; wrap at period with roll-over
// - repetition counter counts clears; at zero next clear gives event
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module mtcu_timer #(
  parameter int CNT_W = mtcu_pkg::CNT_W,
  parameter int REP_W = mtcu_pkg::REP_W
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        syncIn,
  input  wire logic        dmaDone,
  output logic             irqReq,
  output logic             dmaReq,
  output logic      [2:0]  dacTriggerOut,
  output logic             counterTick
);
  localparam int FW = mtcu_pkg::FLG_W;
  localparam int PW = mtcu_pkg::PSC_W;

  function automatic mtcu_pkg::mtcu_reg_t decodeAddr(
    input logic [31:0] a
  );
    if (a[31:8] != 24'h00_0000 || a[1:0] != 2'b00) begin
      return mtcu_pkg::R_NONE;
    end else if (a[7:0] == mtcu_pkg::OFS_CTL0) begin
      return mtcu_pkg::R_CTL0;
    end else if (a[7:0] == mtcu_pkg::OFS_CTL1) begin
      return mtcu_pkg::R_CTL1;
    end else if (a[7:0] == mtcu_pkg::OFS_INTF) begin
      return mtcu_pkg::R_INTF;
    end else if (a[7:0] == mtcu_pkg::OFS_INTFC) begin
      return mtcu_pkg::R_INTFC;
    end else if (a[7:0] == mtcu_pkg::OFS_IEN) begin
      return mtcu_pkg::R_IEN;
    end else if (a[7:0] == mtcu_pkg::OFS_CAR) begin
      return mtcu_pkg::R_CAR;
    end else if (a[7:0] == mtcu_pkg::OFS_CREP) begin
      return mtcu_pkg::R_CREP;
    end else if (a[7:0] == mtcu_pkg::OFS_CNT) begin
      return mtcu_pkg::R_CNT;
    end else if (a[7:4] == mtcu_pkg::OFS_CMP_HI) begin
      return mtcu_pkg::R_CMP;
    end else begin
      return mtcu_pkg::R_NONE;
    end
  endfunction

  mtcu_pkg::mtcu_ctl_t   ctl_ff,    nxt_ctl;
  mtcu_pkg::mtcu_flags_t flg_ff,    nxt_flg;
  logic [FW-1:0]         ienSh_ff,  nxt_ienSh;
  logic [FW-1:0]         ienAct_ff, nxt_ienAct;
  logic [FW-1:0]         denSh_ff,  nxt_denSh;
  logic [FW-1:0]         denAct_ff, nxt_denAct;
  logic [CNT_W-1:0]      carSh_ff,  nxt_carSh;
  logic [CNT_W-1:0]      carAct_ff, nxt_carAct;
  logic [REP_W-1:0]      repSh_ff,  nxt_repSh;
  logic [REP_W-1:0]      repAct_ff, nxt_repAct;
  logic [CNT_W-1:0]      cmpSh_ff   [4];
  logic [CNT_W-1:0]      nxt_cmpSh  [4];
  logic [CNT_W-1:0]      cmpAct_ff  [4];
  logic [CNT_W-1:0]      nxt_cmpAct [4];
  logic [CNT_W-1:0]      cmpEff     [4];
  logic [CNT_W-1:0]      cnt_ff,    nxt_cnt;
  logic [REP_W-1:0]      rep_ff,    nxt_rep;
  logic [PW-1:0]         psc_ff,    nxt_psc;
  logic                  pend_ff,   nxt_pend;
  logic                  run_ff,    nxt_run;
  logic                  enPrev_ff, nxt_enPrev;
  logic                  dmaPend_ff, nxt_dmaPend;
  logic [2:0]            dac_ff,    nxt_dac;
  logic                  dmaReq_ff, nxt_dmaReq;
  logic                  tick_ff,   nxt_tick;
  logic                  sync1_ff,  sync2_ff, sync3_ff;
  logic                  syncLvl_ff, nxt_syncLvl;
  logic                  wrPend_ff, nxt_wrPend;
  logic [31:0]           addr_ff,   nxt_addr;
  logic [31:0]           rdata_ff,  nxt_rdata;

  mtcu_pkg::mtcu_reg_t   wrReg;
  mtcu_pkg::mtcu_reg_t   rdReg;
  logic [3:0]            cmpEvt;
  logic [FW-1:0]         setv;
  logic [FW-1:0]         clrv;
  logic [PW-1:0]         pscLast;
  logic                  addrTake, syncEvt, softRst, softUpd;
  logic                  enabled, enRise, tick, postpone;
  logic                  rstReq, rstApply, adv, rollover, clearEvt;
  logic                  repEvt, updEvt, cntMoved;

  // half mode swaps in period/2 only on the compare path
  assign cmpEff[0] = ctl_ff.halfMode ? (carAct_ff >> 1) : cmpAct_ff[0];
  assign cmpEff[1] = cmpAct_ff[1];
  assign cmpEff[2] = cmpAct_ff[2];
  assign cmpEff[3] = cmpAct_ff[3];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      assign cmpEvt[gi] = cntMoved && (nxt_cnt == cmpEff[gi]);
    end
  endgenerate

  always_comb begin
    // bus side
    addrTake  = hsel && htrans[1] && hready;
    wrReg     = wrPend_ff ? decodeAddr(addr_ff) : mtcu_pkg::R_NONE;
    rdReg     = decodeAddr(haddr);
    nxt_wrPend = addrTake && hwrite;
    nxt_addr  = addrTake ? haddr : addr_ff;
    softRst   = (wrReg == mtcu_pkg::R_CTL1) && hwdata[mtcu_pkg::SRST_BIT];
    softUpd   = (wrReg == mtcu_pkg::R_CTL1) && hwdata[mtcu_pkg::SUP_BIT];
    clrv      = (wrReg == mtcu_pkg::R_INTFC) ? hwdata[FW-1:0] : '0;

    // sync input: level accepted once stages two and three agree
    nxt_syncLvl = (sync2_ff == sync3_ff) ? sync3_ff : syncLvl_ff;
    syncEvt   = (sync2_ff == sync3_ff) && sync3_ff && !syncLvl_ff;

    // control
    nxt_ctl = ctl_ff;
    if (wrReg == mtcu_pkg::R_CTL0) begin
      nxt_ctl = mtcu_pkg::mtcu_ctl_t'(hwdata & mtcu_pkg::CTL0_WMASK);
    end
    enabled    = ctl_ff.cntEnable;
    nxt_enPrev = enabled;
    enRise     = enabled && !enPrev_ff;

    // prescaled counter tick; ratio 2^(div+1), or 1 with extension bit
    pscLast  = ctl_ff.divExt ? '0
             : PW'((10'h001 << ({1'b0, ctl_ff.clkDiv} + 4'h1)) - 10'h001);
    tick     = (psc_ff >= pscLast);
    nxt_psc  = tick ? '0 : psc_ff + PW'(1);
    nxt_tick = tick;
    postpone = !ctl_ff.divExt && (ctl_ff.clkDiv > mtcu_pkg::DIV_LATE);

    // counter reset requests; dropped while disabled
    rstReq   = enabled && (softRst ||
               (syncEvt && ctl_ff.syncRstEn));
    rstApply = enabled && (pend_ff || rstReq)
               && (!postpone || tick);
    nxt_pend = enabled && (pend_ff || rstReq) && !rstApply;

    // start: immediate, or held for a sync event
    if (!enabled) begin
      nxt_run = 1'b0;
    end else if (run_ff) begin
      nxt_run = 1'b1;
    end else if (!ctl_ff.syncStartEn) begin
      nxt_run = 1'b1;
    end else begin
      nxt_run = syncEvt;
    end

    adv      = enabled && run_ff && tick;
    rollover = adv && !rstApply && (cnt_ff == carAct_ff);
    nxt_cnt  = cnt_ff;
    if (rstApply || enRise) begin
      nxt_cnt = '0;
    end else if (adv) begin
      nxt_cnt = rollover ? '0 : cnt_ff + CNT_W'(1);
    end
    cntMoved = rstApply || adv;

    // repetition counter
    clearEvt = rstApply || rollover;
    repEvt   = clearEvt && (rep_ff == '0);
    nxt_rep  = rep_ff;
    if (enRise) begin
      nxt_rep = repAct_ff;
    end else if (clearEvt) begin
      nxt_rep = repEvt ? repAct_ff : rep_ff - REP_W'(1);
    end

    // update sources, all gated by preload
    updEvt = ctl_ff.preloadEn && (softUpd
      || (repEvt && ctl_ff.updOnRep
          && ctl_ff.updSrc != mtcu_pkg::UPDATE_SOURCE_SELECT_ROLL)
      || (dmaDone && ctl_ff.updSrc == mtcu_pkg::UPDATE_SOURCE_SELECT_DMA)
      || (rollover && dmaPend_ff
          && ctl_ff.updSrc == mtcu_pkg::UPDATE_SOURCE_SELECT_ROLL));
    if (softUpd || rollover) begin
      nxt_dmaPend = 1'b0;
    end else if (dmaDone && ctl_ff.updSrc == mtcu_pkg::UPDATE_SOURCE_SELECT_ROLL) begin
      nxt_dmaPend = 1'b1;
    end else begin
      nxt_dmaPend = dmaPend_ff;
    end

    // preloadable registers: shadow always written, active as preload says
    nxt_ienSh  = ienSh_ff;
    nxt_denSh  = denSh_ff;
    nxt_carSh  = carSh_ff;
    nxt_repSh  = repSh_ff;
    nxt_ienAct = ienAct_ff;
    nxt_denAct = denAct_ff;
    nxt_carAct = carAct_ff;
    nxt_repAct = repAct_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_cmpSh[i]  = cmpSh_ff[i];
      nxt_cmpAct[i] = cmpAct_ff[i];
    end
    if (updEvt) begin
      nxt_ienAct = ienSh_ff;
      nxt_denAct = denSh_ff;
      nxt_carAct = carSh_ff;
      nxt_repAct = repSh_ff;
      for (int i = 0; i < 4; i++) begin
        nxt_cmpAct[i] = cmpSh_ff[i];
      end
    end
    if (wrReg == mtcu_pkg::R_IEN) begin
      nxt_ienSh = hwdata[mtcu_pkg::IE_LSB +: FW];
      nxt_denSh = hwdata[mtcu_pkg::DEN_LSB +: FW];
      if (!ctl_ff.preloadEn) begin
        nxt_ienAct = nxt_ienSh;
        nxt_denAct = nxt_denSh;
      end
    end else if (wrReg == mtcu_pkg::R_CAR) begin
      nxt_carSh = hwdata[CNT_W-1:0];
      if (!ctl_ff.preloadEn) begin
        nxt_carAct = nxt_carSh;
      end
    end else if (wrReg == mtcu_pkg::R_CREP) begin
      nxt_repSh = hwdata[REP_W-1:0];
      if (!ctl_ff.preloadEn) begin
        nxt_repAct = nxt_repSh;
      end
    end else if (wrReg == mtcu_pkg::R_CMP) begin
      nxt_cmpSh[addr_ff[3:2]] = hwdata[CNT_W-1:0];
      if (!ctl_ff.preloadEn) begin
        nxt_cmpAct[addr_ff[3:2]] = hwdata[CNT_W-1:0];
      end
    end

    // flags: a set in the clearing cycle wins
    setv    = {repEvt, syncEvt, updEvt, cmpEvt};
    nxt_flg = mtcu_pkg::mtcu_flags_t'((flg_ff & ~clrv) | setv);
    nxt_dmaReq = |(setv & denAct_ff);

    // dac trigger: select 01..11 maps to lines 0..2
    if (updEvt && ctl_ff.dacSel != mtcu_pkg::DAC_OFF) begin
      nxt_dac = 3'(3'h1 << (ctl_ff.dacSel - 2'h1));
    end else begin
      nxt_dac = '0;
    end

    // read data, fetched in the address phase for zero wait states
    nxt_rdata = rdata_ff;
    if (addrTake && !hwrite) begin
      if (rdReg == mtcu_pkg::R_CTL0) begin
        nxt_rdata = 32'(ctl_ff);
      end else if (rdReg == mtcu_pkg::R_CTL1) begin
        nxt_rdata = 32'(pend_ff) << mtcu_pkg::SRST_BIT;
      end else if (rdReg == mtcu_pkg::R_INTF) begin
        nxt_rdata = 32'(flg_ff);
      end else if (rdReg == mtcu_pkg::R_IEN) begin
        nxt_rdata = (32'(ienSh_ff) << mtcu_pkg::IE_LSB)
                  | (32'(denSh_ff) << mtcu_pkg::DEN_LSB);
      end else if (rdReg == mtcu_pkg::R_CAR) begin
        nxt_rdata = 32'(carSh_ff);
      end else if (rdReg == mtcu_pkg::R_CREP) begin
        nxt_rdata = 32'(repSh_ff);
      end else if (rdReg == mtcu_pkg::R_CNT) begin
        nxt_rdata = 32'(cnt_ff);
      end else if (rdReg == mtcu_pkg::R_CMP) begin
        nxt_rdata = 32'(cmpSh_ff[haddr[3:2]]);
      end else begin
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_ff     <= '0;
      flg_ff     <= '0;
      ienSh_ff   <= '0;
      ienAct_ff  <= '0;
      denSh_ff   <= '0;
      denAct_ff  <= '0;
      carSh_ff   <= mtcu_pkg::CAR_RST;
      carAct_ff  <= mtcu_pkg::CAR_RST;
      repSh_ff   <= mtcu_pkg::REP_RST;
      repAct_ff  <= mtcu_pkg::REP_RST;
      for (int i = 0; i < 4; i++) begin
        cmpSh_ff[i]  <= mtcu_pkg::CMP_RST;
        cmpAct_ff[i] <= mtcu_pkg::CMP_RST;
      end
      cnt_ff     <= '0;
      rep_ff     <= '0;
      psc_ff     <= '0;
      pend_ff    <= 1'b0;
      run_ff     <= 1'b0;
      enPrev_ff  <= 1'b0;
      dmaPend_ff <= 1'b0;
      dac_ff     <= '0;
      dmaReq_ff  <= 1'b0;
      tick_ff    <= 1'b0;
      sync1_ff   <= 1'b0;
      sync2_ff   <= 1'b0;
      sync3_ff   <= 1'b0;
      syncLvl_ff <= 1'b0;
      wrPend_ff  <= 1'b0;
      addr_ff    <= '0;
      rdata_ff   <= '0;
    end else begin
      ctl_ff     <= nxt_ctl;
      flg_ff     <= nxt_flg;
      ienSh_ff   <= nxt_ienSh;
      ienAct_ff  <= nxt_ienAct;
      denSh_ff   <= nxt_denSh;
      denAct_ff  <= nxt_denAct;
      carSh_ff   <= nxt_carSh;
      carAct_ff  <= nxt_carAct;
      repSh_ff   <= nxt_repSh;
      repAct_ff  <= nxt_repAct;
      for (int i = 0; i < 4; i++) begin
        cmpSh_ff[i]  <= nxt_cmpSh[i];
        cmpAct_ff[i] <= nxt_cmpAct[i];
      end
      cnt_ff     <= nxt_cnt;
      rep_ff     <= nxt_rep;
      psc_ff     <= nxt_psc;
      pend_ff    <= nxt_pend;
      run_ff     <= nxt_run;
      enPrev_ff  <= nxt_enPrev;
      dmaPend_ff <= nxt_dmaPend;
      dac_ff     <= nxt_dac;
      dmaReq_ff  <= nxt_dmaReq;
      tick_ff    <= nxt_tick;
      sync1_ff   <= syncIn;
      sync2_ff   <= sync1_ff;
      sync3_ff   <= sync2_ff;
      syncLvl_ff <= nxt_syncLvl;
      wrPend_ff  <= nxt_wrPend;
      addr_ff    <= nxt_addr;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign hrdata        = rdata_ff;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign irqReq        = |(flg_ff & ienAct_ff);
  assign dmaReq        = dmaReq_ff;
  assign dacTriggerOut = dac_ff;
  assign counterTick   = tick_ff;
endmodule

/* File: tb/mtcu_timer_monitor.sv */
// port-level assertion checker for the master timing unit
`timescale 1ns/10ps
module mtcu_timer_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irqReq,
  input wire logic        dmaReq,
  input wire logic [2:0]  dacTriggerOut,
  input wire logic        counterTick
);
  mtcu_pkg::mtcu_ctl_t ctlSeen_ff;
  mtcu_pkg::mtcu_ctl_t nxt_ctlSeen;
  logic                wrPh_ff;
  logic                nxt_wrPh;
  logic                rdPh_ff;
  logic                nxt_rdPh;
  logic [7:0]          adr_ff;
  logic [7:0]          nxt_adr;
  logic [2:0]          dacExp;

  // mirror of the control word, so trigger checks know the select
  always_comb begin
    nxt_wrPh = hsel && htrans[1] && hready && hwrite;
    nxt_rdPh = hsel && htrans[1] && hready && !hwrite;
    nxt_adr = haddr[7:0];
    nxt_ctlSeen = ctlSeen_ff;
    if (wrPh_ff && adr_ff == mtcu_pkg::OFS_CTL0) begin
      nxt_ctlSeen = mtcu_pkg::mtcu_ctl_t'(hwdata & mtcu_pkg::CTL0_WMASK);
    end
    dacExp = 3'b001 << (ctlSeen_ff.dacSel - 2'd1);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctlSeen_ff <= '0;
      wrPh_ff <= 1'b0;
      rdPh_ff <= 1'b0;
      adr_ff <= 8'h00;
    end else begin
      ctlSeen_ff <= nxt_ctlSeen;
      wrPh_ff <= nxt_wrPh;
      rdPh_ff <= nxt_rdPh;
      adr_ff <= nxt_adr;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");

  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");

  property p_rst_quiet;
    $rose(rst_n) |-> !irqReq && !dmaReq && dacTriggerOut == 3'b000
      && !counterTick;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");

  property p_dac_onehot;
    $onehot0(dacTriggerOut);
  endproperty
  a_dac_onehot: assert property (p_dac_onehot)
    else $error("several triggers at once");

  property p_dac_off;
    ctlSeen_ff.dacSel == mtcu_pkg::DAC_OFF
      && $past(ctlSeen_ff.dacSel) == mtcu_pkg::DAC_OFF
      |-> dacTriggerOut == 3'b000;
  endproperty
  a_dac_off: assert property (p_dac_off)
    else $error("trigger while select off");

  property p_soft_upd;
    wrPh_ff && adr_ff == mtcu_pkg::OFS_CTL1 && hwdata[1]
      && ctlSeen_ff.preloadEn && ctlSeen_ff.dacSel != mtcu_pkg::DAC_OFF
      |=> dacTriggerOut == $past(dacExp);
  endproperty
  a_soft_upd: assert property (p_soft_upd)
    else $error("soft update gave no trigger");

  property p_rd_zero;
    rdPh_ff && (adr_ff == mtcu_pkg::OFS_INTFC || adr_ff > 8'h2c)
      |-> hrdata == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("nonzero read of write-only place");

  property p_rd_ctl1;
    rdPh_ff && adr_ff == mtcu_pkg::OFS_CTL1 |-> hrdata[31:1] == 31'h0;
  endproperty
  a_rd_ctl1: assert property (p_rd_ctl1)
    else $error("command word reads extra bits");
endmodule

bind mtcu_timer mtcu_timer_monitor mon_u (.clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .irqReq, .dmaReq, .dacTriggerOut, .counterTick);

/* File: tb/mtcu_dma_model.sv */
// dma controller stand-in: answers a request with a burst-end pulse
`timescale 1ns/10ps
module mtcu_dma_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       dmaReq,
  input  wire logic [3:0] lag,
  output logic            dmaDone
);
  logic [4:0] left;

  // requests during a burst merge into it, as a real burst would
  always @(posedge clk) begin
    if (!rst_n) begin
      left <= 5'h00;
      dmaDone <= 1'b0;
    end else if (left != 5'h00) begin
      left <= left - 5'h01;
      dmaDone <= (left == 5'h01);
    end else begin
      dmaDone <= 1'b0;
      if (dmaReq) begin
        left <= {1'b0, lag} + 5'h01;
      end
    end
  end
endmodule

/* File: tb/master_timer_compare_update_tb_top.sv */
// self-checking bench for the master timing unit
`timescale 1ns/10ps
module master_timer_compare_update_tb_top;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        syncIn;
  logic        dmaDone;
  logic        hreadyout;
  logic        hresp;
  logic        irqReq;
  logic        dmaReq;
  logic        counterTick;
  logic [1:0]  htrans;
  logic [2:0]  dacTriggerOut;
  logic [3:0]  lag;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] keep;
  logic [31:0] seed;
  logic [2:0]  dacQ[$];
  int          failures;
  int          tests_run;
  int          flg;
  int          i;

  mtcu_timer dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .syncIn(syncIn), .dmaDone(dmaDone), .irqReq(irqReq),
    .dmaReq(dmaReq), .dacTriggerOut(dacTriggerOut),
    .counterTick(counterTick));
  mtcu_dma_model dma_u (.clk(clk), .rst_n(rst_n), .dmaReq(dmaReq),
    .lag(lag), .dmaDone(dmaDone));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dacTriggerOut != 3'b000) dacQ.push_back(dacTriggerOut);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single word transfer; holds each phase until ready is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    seed = 32'h5499;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    syncIn = 1'b0;
    lag = 4'h2;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctl0", mtcu_pkg::OFS_CTL0, 32'h0);
    rdc("period", mtcu_pkg::OFS_CAR, 32'hffff);
    rdc("rep", mtcu_pkg::OFS_CREP, 32'h0);
    rdc("ien", mtcu_pkg::OFS_IEN, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rdc("unmapped", 8'h40, 32'h0);
    // short period, random compares inside it
    wr(mtcu_pkg::OFS_CAR, 32'h7);
    for (i = 0; i < 4; i++) begin
      rdc("cmp", {mtcu_pkg::OFS_CMP_HI, 2'(i), 2'b00}, 32'h0);
      wr({mtcu_pkg::OFS_CMP_HI, 2'(i), 2'b00}, rnd() & 32'h7);
    end
    wr(mtcu_pkg::OFS_CTL0, 32'h1);
    repeat (60) @(posedge clk);
    bus(1'b0, mtcu_pkg::OFS_CNT, 32'h0);
    chk("cnt in period", 32'h1, {31'h0, rd <= 32'h7});
    wr(mtcu_pkg::OFS_CTL0, 32'h0);
    flg = 32'h4f;
    rdc("flags", mtcu_pkg::OFS_INTF, flg);
    wr(mtcu_pkg::OFS_INTFC, 32'h5);
    flg = flg & ~32'h5;
    rdc("flags", mtcu_pkg::OFS_INTF, flg);
    rdc("clr reg", mtcu_pkg::OFS_INTFC, 32'h0);
    wr(mtcu_pkg::OFS_IEN, 32'h2);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irqReq});
    wr(mtcu_pkg::OFS_IEN, 32'h1);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irqReq});
    // soft reset while stopped is dropped
    bus(1'b0, mtcu_pkg::OFS_CNT, 32'h0);
    keep = rd;
    wr(mtcu_pkg::OFS_CTL1, 32'h1);
    rdc("srst", mtcu_pkg::OFS_CTL1, 32'h0);
    rdc("cnt kept", mtcu_pkg::OFS_CNT, keep);
    // slow prescale: reset waits for the next tick
    wr(mtcu_pkg::OFS_CTL0, 32'h6001);
    repeat (400) @(posedge clk);
    do @(posedge clk); while (counterTick !== 1'b1);
    wr(mtcu_pkg::OFS_CTL1, 32'h1);
    rdc("srst late", mtcu_pkg::OFS_CTL1, 32'h1);
    for (i = 0; i < 100 && rd[0] !== 1'b0; i++) begin
      bus(1'b0, mtcu_pkg::OFS_CTL1, 32'h0);
    end
    chk("srst self", 32'h0, {31'h0, rd[0]});
    rdc("cnt reset", mtcu_pkg::OFS_CNT, 32'h0);
    // start and reset from the sync input
    wr(mtcu_pkg::OFS_CTL0, 32'h0);
    wr(mtcu_pkg::OFS_CTL0, 32'h19);
    repeat (20) @(posedge clk);
    rdc("cnt held", mtcu_pkg::OFS_CNT, 32'h0);
    syncIn <= 1'b1;
    repeat (4) @(posedge clk);
    syncIn <= 1'b0;
    repeat (9) @(posedge clk);
    bus(1'b0, mtcu_pkg::OFS_CNT, 32'h0);
    chk("cnt started", 32'h1, {31'h0, rd != 32'h0});
    bus(1'b0, mtcu_pkg::OFS_INTF, 32'h0);
    chk("sync flag", 32'h20, rd & 32'h20);
    // preload with software updates and every trigger select
    wr(mtcu_pkg::OFS_CTL0, 32'h0);
    wr(mtcu_pkg::OFS_INTFC, 32'h7f);
    rdc("flags", mtcu_pkg::OFS_INTF, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(mtcu_pkg::OFS_CTL0, 32'h4 | (32'(i) << 10));
      wr(mtcu_pkg::OFS_CTL1, 32'h2);
      repeat (2) @(posedge clk);
      chk("trig count", (i == 0) ? 32'h0 : 32'h1, dacQ.size());
      if (dacQ.size() > 0) begin
        chk("trig", 32'h1 << (i - 1), dacQ.pop_front());
      end
    end
    rdc("upd flag", mtcu_pkg::OFS_INTF, 32'h10);
    wr(mtcu_pkg::OFS_IEN, 32'h1_0010);
    @(posedge clk);
    chk("irq held", 32'h0, {31'h0, irqReq});
    wr(mtcu_pkg::OFS_CTL1, 32'h2);
    @(posedge clk);
    chk("irq loaded", 32'h1, {31'h0, irqReq});
    wr(mtcu_pkg::OFS_INTFC, 32'h10);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irqReq});
    dacQ.delete();
    // burst completion from the far side loads the shadows
    lag <= 4'(rnd());
    wr(mtcu_pkg::OFS_CTL0, 32'h505);
    repeat (300) @(posedge clk);
    chk("dma update", 32'h1, {31'h0, dacQ.size() != 0});
    // half mode: compare 0 beyond the period, so only period/2 can hit
    wr(mtcu_pkg::OFS_CTL0, 32'h2);
    wr(mtcu_pkg::OFS_CAR, 32'h10);
    wr({mtcu_pkg::OFS_CMP_HI, 4'h0}, 32'h20);
    wr(mtcu_pkg::OFS_INTFC, 32'h7f);
    wr(mtcu_pkg::OFS_CTL0, 32'h3);
    repeat (60) @(posedge clk);
    bus(1'b0, mtcu_pkg::OFS_INTF, 32'h0);
    chk("half cmp0", 32'h1, rd & 32'h1);
    rdc("cmp0 kept", {mtcu_pkg::OFS_CMP_HI, 4'h0}, 32'h20);
    // repetition event updates with preload and source 00
    wr(mtcu_pkg::OFS_CTL0, 32'h25);
    wr(mtcu_pkg::OFS_INTFC, 32'h7f);
    repeat (60) @(posedge clk);
    bus(1'b0, mtcu_pkg::OFS_INTF, 32'h0);
    chk("rep update", 32'h50, rd & 32'h50);
    tally_and_finish();
  end
endmodule
